// ---- scd_pkg.sv ----
// Constants, field layouts and carrier types of the sinc3 conversion path
// Assumes one 100 MHz system clock; analog side takes the control outputs
// Behaviour
// - Modulator samples once every eight master clock periods.
// - One fixed output rate of 8 kSPS, shared by all eight channels.
// - Each channel filters its bitstream with a third-order sinc (cubed boxcar).
// - Sinc stage runs at modulator rate, decimates to parallel words; ratio sets rate.
// - After an input step the output settles within three output periods.
// - After conversion start rises, words need a settling interval before valid.
// - Mux code 011 selects supply monitor: half AVDD, DVDD/4 on channels 3 and 4.
// - Gain per channel is one of 1, 2 or 8 from its settings register.
// - Reference level bit selects 4 V, otherwise 2.4 V internal reference.
// - A configuration bit powers down the internal reference buffer.
// - After reset the reference buffer is powered down (external reference).
// - Clock source pin picks internal oscillator or external master clock.
// - Clock-output enable bit drives the oscillator clock out on the clock pin.
// - Source low: pin is input; high: pin floats unless output is enabled.
// - Result is 16-bit two's complement, saturating at 7fff and 8000.
// - Mux code 001 shorts both inputs to the reference midpoint.
package scd_pkg;

  localparam int SCD_NUM_CH         = 8;
  localparam int SCD_WORD_W         = 16;
  localparam int SCD_CLK_HZ         = 100_000_000;
  localparam int SCD_MCLK_HZ        = 2_048_000;
  localparam int SCD_MOD_DIV        = 8;
  localparam int SCD_OUT_RATE_HZ    = 8_000;
  localparam int SCD_SINC_ORDER     = 3;
  localparam int SCD_SETTLE_PERIODS = 3;
  localparam int SCD_DROP_WORDS     = SCD_SETTLE_PERIODS - 1;
  localparam int SCD_FIFO_DEPTH     = 16;

  localparam logic [2:0] SCD_MUX_NORMAL = 3'h0;
  localparam logic [2:0] SCD_MUX_SHORT  = 3'h1;
  localparam logic [2:0] SCD_MUX_SUPPLY = 3'h3;

  localparam logic [1:0] SCD_GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] SCD_GAIN_CODE_X2 = 2'h1;
  localparam logic [1:0] SCD_GAIN_CODE_X8 = 2'h2;

  // Channels 3 and 4 (bits 2 and 3) watch the digital supply
  localparam logic [7:0] SCD_DVDD_MON_CHANS = 8'h0c;

  localparam logic [15:0] SCD_POS_FULL = 16'h7fff;
  localparam logic [15:0] SCD_NEG_FULL = 16'h8000;

  localparam logic [2:0] SCD_RST_MUX        = 3'h0;
  localparam logic [1:0] SCD_RST_GAIN       = 2'h0;
  localparam logic       SCD_RST_CLK_OUT_EN = 1'b0;
  localparam logic       SCD_RST_REF_HIGH   = 1'b0;
  localparam logic       SCD_RST_REFBUF_PD  = 1'b1;

  typedef enum logic [1:0] {
    SCD_GAIN_X1 = 2'b00,
    SCD_GAIN_X2 = 2'b01,
    SCD_GAIN_X8 = 2'b10
  } scd_gain_type;

  typedef enum logic [1:0] {
    SCD_IDLE   = 2'b00,
    SCD_SETTLE = 2'b01,
    SCD_RUN    = 2'b10
  } scd_conv_type;

  // One channel_settings_reg
  typedef struct packed {
    logic [2:0] mux;
    logic [1:0] gain;
  } scd_chan_cfg_type;

  // channel_settings_reg x8 plus the config_reg_one..three bits used here
  typedef struct packed {
    scd_chan_cfg_type [SCD_NUM_CH-1:0] chan;
    logic                              clk_out_en;
    logic                              ref_high_level_select;
    logic                              ref_buffer_powerdown;
  } scd_cfg_type;

  localparam scd_cfg_type SCD_CFG_RST = '{
    chan:                  {SCD_NUM_CH{SCD_RST_MUX, SCD_RST_GAIN}},
    clk_out_en:            SCD_RST_CLK_OUT_EN,
    ref_high_level_select: SCD_RST_REF_HIGH,
    ref_buffer_powerdown:  SCD_RST_REFBUF_PD
  };

  // Per-channel controls handed to the analog front end
  typedef struct packed {
    logic [2:0]   mux;
    logic         short_in;
    logic         supply_monitor_pos;
    logic         mon_dvdd;
    scd_gain_type gain;
  } scd_chan_ana_type;

  typedef struct packed {
    logic [SCD_NUM_CH-1:0][SCD_WORD_W-1:0] word;
  } scd_frame_type;

endpackage

// ---- scd_fifo.sv ----
// Frame FIFO with a registered output word
// Assumes the consumer may stall; in_ready_o falls while storage is full
`timescale 1ns/1ps
module scd_fifo #(
  parameter int W     = 128,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("scd_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } scd_fifo_state_type;

  scd_fifo_state_type r;
  scd_fifo_state_type next_r;
  logic               push;
  logic               pop;

  assign in_ready_o  = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = r.ov;
  assign out_data_o  = r.od;

  always_comb begin
    next_r = r;
    push   = in_valid_i && in_ready_o;
    pop    = (r.cnt != '0) && (!r.ov || out_ready_i);
    if (push) begin
      next_r.mem[r.wp] = in_data_i;
      next_r.wp        = r.wp + 1'b1;
    end
    if (pop) begin
      next_r.od = r.mem[r.rp];
      next_r.ov = 1'b1;
      next_r.rp = r.rp + 1'b1;
    end else if (out_ready_i) begin
      next_r.ov = 1'b0;
    end
    next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ---- scd_conv_path.sv ----
// Eight-channel modulator timing, sinc3 decimators and channel controls
// Assumes synchronous pins; analog mux, gain and reference follow the outputs
`timescale 1ns/1ps
module scd_conv_path
  import scd_pkg::*;
#(
  parameter int CLK_HZ   = SCD_CLK_HZ,
  parameter int MCLK_HZ  = SCD_MCLK_HZ,
  parameter int OUT_HZ   = SCD_OUT_RATE_HZ,
  parameter int DECIM    = SCD_MCLK_HZ / SCD_MOD_DIV / SCD_OUT_RATE_HZ,
  parameter int FIFO_DEP = SCD_FIFO_DEPTH
) (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    clock_source_select_pin_i,
  input  wire logic                    ext_clk_i,
  input  wire logic                    start_i,
  input  wire logic [SCD_NUM_CH-1:0]   mod_bits_i,
  input  wire logic                    cfg_we_i,
  input  wire scd_cfg_type             cfg_i,
  input  wire logic                    frame_ready_i,
  output logic                         frame_valid_o,
  output scd_frame_type                frame_o,
  output logic                         overrun_o,
  output logic                         converting_o,
  output scd_chan_ana_type [SCD_NUM_CH-1:0] chan_ana_o,
  output logic                         ref_high_o,
  output logic                         ref_buffer_powerdown_o,
  output logic                         clk_pin_o,
  output logic                         clk_pin_oe_o
);

  localparam int DW    = $clog2(DECIM);
  localparam int ACC_W = SCD_SINC_ORDER * DW + 2;
  localparam int SHIFT = SCD_SINC_ORDER * DW - (SCD_WORD_W - 1);

  // The cascade gain is DECIM cubed; scaling is a plain shift, so the
  // ratio must be a power of two no smaller than 32.
  if ((1 << DW) != DECIM || SHIFT < 0) begin : g_chk_decim
    $error("decimation ratio must be a power of two of at least 32");
  end
  if (DECIM * SCD_MOD_DIV * OUT_HZ != MCLK_HZ) begin : g_chk_rate
    $error("master clock over 8 over output rate must be exact");
  end
  if (2 * MCLK_HZ >= CLK_HZ) begin : g_chk_osc
    $error("oscillator model needs the system clock above twice its rate");
  end

  localparam logic [31:0] OSC_STEP = 32'(2 * MCLK_HZ);
  localparam logic [31:0] OSC_WRAP = 32'(CLK_HZ);
  localparam logic [2:0]  MDIV_TOP = 3'(SCD_MOD_DIV - 1);
  localparam logic [DW-1:0] DCNT_TOP = DW'(DECIM - 1);
  localparam logic [1:0]  DROP_TOP = 2'(SCD_DROP_WORDS - 1);

  typedef logic [SCD_NUM_CH-1:0][ACC_W-1:0] scd_acc_type;

  typedef struct packed {
    logic [31:0]                      phase;
    logic                             osc;
    logic                             ext_q;
    logic [2:0]                       mdiv;
    logic [DW-1:0]                    dcnt;
    logic [1:0]                       drop;
    logic                             start_q;
    scd_conv_type                     conv;
    logic                             converting;
    scd_cfg_type                      cfg;
    scd_acc_type                      i1;
    scd_acc_type                      i2;
    scd_acc_type                      i3;
    scd_acc_type                      d1;
    scd_acc_type                      d2;
    scd_acc_type                      d3;
    scd_chan_ana_type [SCD_NUM_CH-1:0] ana;
    logic                             ref_high;
    logic                             refbuf_pd;
    logic                             clk_pin;
    logic                             clk_oe;
    logic                             overrun;
    logic                             push;
    scd_frame_type                    frame;
  } scd_state_type;

  scd_state_type r;
  scd_state_type next_r;

  logic              fifo_in_ready;
  logic [31:0]       phase_sum;
  logic              osc_wrap;
  logic              osc_rise;
  logic              ext_rise;
  logic              master_tick;
  logic              mod_tick;
  logic              word_tick;
  logic              start_rise;
  logic [ACC_W-1:0]  x;
  logic [ACC_W-1:0]  c1;
  logic [ACC_W-1:0]  c2;
  logic [ACC_W-1:0]  c3;
  logic signed [ACC_W-1:0] scaled;
  scd_cfg_type       cfg_now;

  always_comb begin
    next_r = r;
    x      = '0;
    c1     = '0;
    c2     = '0;
    c3     = '0;
    scaled = '0;

    // Internal oscillator: phase accumulator toggles a square wave
    phase_sum = r.phase + OSC_STEP;
    osc_wrap  = (phase_sum >= OSC_WRAP);
    next_r.phase = osc_wrap ? phase_sum - OSC_WRAP : phase_sum;
    next_r.osc   = r.osc ^ osc_wrap;
    osc_rise     = osc_wrap && !r.osc;

    // External clock pin arrives synchronous, so an edge compare suffices
    next_r.ext_q = ext_clk_i;
    ext_rise     = ext_clk_i && !r.ext_q;

    master_tick = clock_source_select_pin_i ? osc_rise : ext_rise;

    // Pin drives the oscillator only when it is the source and output is on
    next_r.clk_oe  = clock_source_select_pin_i && r.cfg.clk_out_en;
    next_r.clk_pin = next_r.clk_oe && next_r.osc;

    // Modulator sample strobe: every eighth master clock edge
    mod_tick = master_tick && (r.mdiv == MDIV_TOP);
    if (master_tick) begin
      next_r.mdiv = (r.mdiv == MDIV_TOP) ? 3'h0 : r.mdiv + 3'h1;
    end

    // One shared decimation counter keeps all channels in lockstep
    word_tick = mod_tick && (r.dcnt == DCNT_TOP);
    if (mod_tick) begin
      next_r.dcnt = (r.dcnt == DCNT_TOP) ? '0 : r.dcnt + 1'b1;
    end

    // Configuration is taken whole on a write strobe
    cfg_now = r.cfg;
    if (cfg_we_i) begin
      cfg_now = cfg_i;
    end
    next_r.cfg       = cfg_now;
    next_r.ref_high  = cfg_now.ref_high_level_select;
    next_r.refbuf_pd = cfg_now.ref_buffer_powerdown;

    for (int ch = 0; ch < SCD_NUM_CH; ch++) begin
      next_r.ana[ch].mux      = cfg_now.chan[ch].mux;
      next_r.ana[ch].short_in = (cfg_now.chan[ch].mux == SCD_MUX_SHORT);
      next_r.ana[ch].supply_monitor_pos =
        (cfg_now.chan[ch].mux == SCD_MUX_SUPPLY);
      next_r.ana[ch].mon_dvdd = next_r.ana[ch].supply_monitor_pos &&
                                SCD_DVDD_MON_CHANS[ch];
      // Reserved gain code falls back to unity, the safe choice for monitoring
      unique case (cfg_now.chan[ch].gain)
        SCD_GAIN_CODE_X2: next_r.ana[ch].gain = SCD_GAIN_X2;
        SCD_GAIN_CODE_X8: next_r.ana[ch].gain = SCD_GAIN_X8;
        default:          next_r.ana[ch].gain = SCD_GAIN_X1;
      endcase
    end

    // Sinc3: three integrators at modulator rate, three combs at word rate
    for (int ch = 0; ch < SCD_NUM_CH; ch++) begin
      x = mod_bits_i[ch] ? ACC_W'(1) : {ACC_W{1'b1}};
      if (mod_tick) begin
        next_r.i1[ch] = r.i1[ch] + x;
        // Unpipelined chain: stage registers would shift the window by two
        // samples and let a pre-start sample leak into the first valid word
        next_r.i2[ch] = r.i2[ch] + next_r.i1[ch];
        next_r.i3[ch] = r.i3[ch] + next_r.i2[ch];
      end
      if (word_tick) begin
        c1 = r.i3[ch] - r.d1[ch];
        c2 = c1 - r.d2[ch];
        c3 = c2 - r.d3[ch];
        next_r.d1[ch] = r.i3[ch];
        next_r.d2[ch] = c1;
        next_r.d3[ch] = c2;
        scaled = $signed(c3) >>> SHIFT;
        if (scaled > $signed(ACC_W'(SCD_POS_FULL))) begin
          next_r.frame.word[ch] = SCD_POS_FULL;
        end else if (scaled < -$signed(ACC_W'(SCD_NEG_FULL))) begin
          next_r.frame.word[ch] = SCD_NEG_FULL;
        end else begin
          next_r.frame.word[ch] = scaled[SCD_WORD_W-1:0];
        end
      end
    end

    // Conversion control
    next_r.start_q = start_i;
    start_rise     = start_i && !r.start_q;
    next_r.push    = 1'b0;

    unique case (r.conv)
      SCD_IDLE: begin
        next_r.conv = SCD_IDLE;
      end
      SCD_SETTLE: begin
        // Early words come from a partly filled window and are dropped
        if (word_tick) begin
          if (r.drop == DROP_TOP) begin
            next_r.conv = SCD_RUN;
          end else begin
            next_r.drop = r.drop + 2'h1;
          end
        end
      end
      SCD_RUN: begin
        // A converter cannot pause; a full FIFO costs the word and flags it
        if (word_tick) begin
          next_r.push    = fifo_in_ready;
          next_r.overrun = r.overrun || !fifo_in_ready;
        end
      end
      default: begin
        next_r.conv = SCD_IDLE;
      end
    endcase

    if (!start_i) begin
      next_r.conv = SCD_IDLE;
    end

    // Start flushes every filter and restarts decimation phase together
    if (start_rise) begin
      next_r.conv    = SCD_SETTLE;
      next_r.drop    = 2'h0;
      next_r.mdiv    = 3'h0;
      next_r.dcnt    = '0;
      next_r.i1      = '0;
      next_r.i2      = '0;
      next_r.i3      = '0;
      next_r.d1      = '0;
      next_r.d2      = '0;
      next_r.d3      = '0;
      next_r.overrun = 1'b0;
      next_r.push    = 1'b0;
    end
    next_r.converting = (next_r.conv == SCD_RUN);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r           <= '0;
      r.conv      <= SCD_IDLE;
      r.cfg       <= SCD_CFG_RST;
      r.ref_high  <= SCD_RST_REF_HIGH;
      r.refbuf_pd <= SCD_RST_REFBUF_PD;
    end else begin
      r <= next_r;
    end
  end

  scd_fifo #(
    .W     ($bits(scd_frame_type)),
    .DEPTH (FIFO_DEP)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (r.push),
    .in_data_i   (r.frame),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (frame_valid_o),
    .out_data_o  (frame_o),
    .out_ready_i (frame_ready_i)
  );

  assign overrun_o              = r.overrun;
  assign converting_o           = r.converting;
  assign chan_ana_o             = r.ana;
  assign ref_high_o             = r.ref_high;
  assign ref_buffer_powerdown_o = r.refbuf_pd;
  assign clk_pin_o              = r.clk_pin;
  assign clk_pin_oe_o           = r.clk_oe;

endmodule

// ---- scd_conv_path_assertions.sv ----
// Port checker for the sinc3 conversion path
// Assumes the bind below; one clk_i domain with resetn_i active low
`timescale 1ns/1ps
module scd_conv_path_assertions
  import scd_pkg::*;
(
  input wire logic                          clk_i,
  input wire logic                          resetn_i,
  input wire logic                          clock_source_select_pin_i,
  input wire logic                          start_i,
  input wire logic                          cfg_we_i,
  input wire scd_cfg_type                   cfg_i,
  input wire logic                          frame_ready_i,
  input wire logic                          frame_valid_o,
  input wire scd_frame_type                 frame_o,
  input wire logic                          overrun_o,
  input wire logic                          converting_o,
  input wire scd_chan_ana_type [SCD_NUM_CH-1:0] chan_ana_o,
  input wire logic                          ref_high_o,
  input wire logic                          ref_buffer_powerdown_o,
  input wire logic                          clk_pin_o,
  input wire logic                          clk_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Reserved code 11 falls back to unity gain
  function automatic scd_gain_type gmap(input logic [1:0] c);
    return (c == 2'h2) ? SCD_GAIN_X8 : (c == 2'h1) ? SCD_GAIN_X2 : SCD_GAIN_X1;
  endfunction

  a_reset_refbuf: assert property ($rose(resetn_i) |->
    ref_buffer_powerdown_o && !ref_high_o && !clk_pin_oe_o) else $error("reset output state");
  a_ref_level: assert property (cfg_we_i |=>
    ref_high_o == $past(cfg_i.ref_high_level_select)) else $error("reference level");
  a_refbuf_pd: assert property (cfg_we_i |=>
    ref_buffer_powerdown_o == $past(cfg_i.ref_buffer_powerdown)) else $error("refbuf");
  a_ref_hold: assert property (!cfg_we_i [*2] |=>
    $stable(ref_high_o) && $stable(ref_buffer_powerdown_o)) else $error("reference moved");
  a_gain_map: assert property (cfg_we_i |=>
    chan_ana_o[7].gain == gmap($past(cfg_i.chan[7].gain))) else $error("gain map");
  a_supply_pos: assert property (chan_ana_o[0].supply_monitor_pos ==
    (chan_ana_o[0].mux == SCD_MUX_SUPPLY) && !chan_ana_o[0].mon_dvdd) else $error("monitor");
  a_dvdd_mon: assert property (chan_ana_o[2].mon_dvdd ==
    (chan_ana_o[2].mux == SCD_MUX_SUPPLY)) else $error("digital supply monitor");
  a_short_in: assert property (chan_ana_o[1].short_in ==
    (chan_ana_o[1].mux == SCD_MUX_SHORT)) else $error("short input");
  a_pin_float: assert property (!clock_source_select_pin_i [*2] |->
    !clk_pin_oe_o) else $error("clock pin driven as input");
  a_pin_quiet: assert property (!clk_pin_oe_o |-> !clk_pin_o) else $error("pin idle");
  a_frame_hold: assert property (frame_valid_o && !frame_ready_i |=>
    frame_valid_o && $stable(frame_o)) else $error("frame dropped while stalled");
  a_start_flush: assert property ($rose(start_i) |=>
    (!overrun_o && !converting_o) [*8]) else $error("start did not flush");
  a_stop_idle: assert property (!start_i [*2] |=> !converting_o) else $error("still running");

  c_frame_taken: cover property (frame_valid_o && frame_ready_i);
  c_overrun: cover property ($rose(overrun_o));
  c_pin_out: cover property ($rose(clk_pin_oe_o));
endmodule

bind scd_conv_path scd_conv_path_assertions u_scd_conv_path_assertions (
  .clk_i(clk_i), .resetn_i(resetn_i), .clock_source_select_pin_i(clock_source_select_pin_i),
  .start_i(start_i), .cfg_we_i(cfg_we_i), .cfg_i(cfg_i), .frame_ready_i(frame_ready_i),
  .frame_valid_o(frame_valid_o), .frame_o(frame_o), .overrun_o(overrun_o),
  .converting_o(converting_o), .chan_ana_o(chan_ana_o), .ref_high_o(ref_high_o),
  .ref_buffer_powerdown_o(ref_buffer_powerdown_o), .clk_pin_o(clk_pin_o),
  .clk_pin_oe_o(clk_pin_oe_o));

// ---- scd_far_side.sv ----
// Far side model: modulator bits, external master clock and frame consumer
// Assumes clk_i is the system clock; the consumer stalls while stall_i is high
`timescale 1ns/1ps
module scd_far_side
  import scd_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            resetn_i,
  input  wire logic [7:0]      pattern_i,
  input  wire logic            stall_i,
  input  wire logic            frame_valid_i,
  input  wire scd_frame_type   frame_i,
  output logic [7:0]           mod_bits_o,
  output logic                 ext_clk_o,
  output logic                 frame_ready_o,
  output logic [15:0]          taken_o,
  output scd_frame_type        last_o
);
  logic ph;

  // Constant bitstreams drive each channel to a full-scale code
  assign mod_bits_o    = pattern_i;
  assign frame_ready_o = !stall_i;

  // External clock of four system periods, free running as a crystal would
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ph        <= 1'b0;
      ext_clk_o <= 1'b0;
      taken_o   <= '0;
      last_o    <= '0;
    end else begin
      ph <= !ph;
      if (ph) begin
        ext_clk_o <= !ext_clk_o;
      end
      if (frame_valid_i && frame_ready_o) begin
        taken_o <= taken_o + 16'h1;
        last_o  <= frame_i;
      end
    end
  end
endmodule

// ---- scd_conv_path_tb.sv ----
// Self-checking bench for the sinc3 conversion path
// Assumes a fast master clock so one output period is about 781 system cycles on the oscillator and 1024 on the external clock
`timescale 1ns/1ps
module scd_conv_path_tb;
  import scd_pkg::*;
  localparam int PER_INT = 781;
  localparam int PER_EXT = 1024;
  logic clk, resetn, sel, start, cfg_we, stall, mod_ext, ready, fvalid, overrun, conv;
  logic ref_high, refbuf, pin, pin_oe;
  logic [7:0] mod, pat;
  logic [15:0] taken;
  scd_cfg_type cfg;
  scd_frame_type frame, last;
  scd_chan_ana_type [SCD_NUM_CH-1:0] ana;
  int miscompares, comparisons, cyc;

  scd_conv_path #(.MCLK_HZ(32_768_000), .OUT_HZ(128_000), .DECIM(32)) u_scd_conv_path (
    .clk_i(clk), .resetn_i(resetn), .clock_source_select_pin_i(sel), .ext_clk_i(mod_ext),
    .start_i(start), .mod_bits_i(mod), .cfg_we_i(cfg_we), .cfg_i(cfg), .frame_ready_i(ready),
    .frame_valid_o(fvalid), .frame_o(frame), .overrun_o(overrun), .converting_o(conv),
    .chan_ana_o(ana), .ref_high_o(ref_high), .ref_buffer_powerdown_o(refbuf),
    .clk_pin_o(pin), .clk_pin_oe_o(pin_oe));
  scd_far_side u_scd_far_side (.clk_i(clk), .resetn_i(resetn), .pattern_i(pat),
    .stall_i(stall), .frame_valid_i(fvalid), .frame_i(frame), .mod_bits_o(mod),
    .ext_clk_o(mod_ext), .frame_ready_o(ready), .taken_o(taken), .last_o(last));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard sized well above the roughly 30k cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wcfg();
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    tick(3);
  endtask
  task automatic wait_frame(input int lim, output int n);
    logic [15:0] c0;
    c0 = taken;
    n = 0;
    while (taken == c0 && n < lim) begin
      tick(1);
      n++;
    end
    chk("frame arrived", 1, taken != c0);
  endtask
  task automatic chk_frame();
    for (int ch = 0; ch < SCD_NUM_CH; ch++) begin
      chk("channel word", pat[ch] ? SCD_POS_FULL : SCD_NEG_FULL, last.word[ch]);
    end
  endtask

  task automatic t_reset();
    chk("refbuf at reset", 1, refbuf);
    chk("ref level at reset", 0, ref_high);
    chk("pin enable at reset", 0, pin_oe);
    chk("pin at reset", 0, pin);
    chk("frame valid at reset", 0, fvalid);
    chk("converting at reset", 0, conv);
    chk("gain at reset", SCD_GAIN_X1, ana[0].gain);
  endtask

  task automatic t_chan_cfg();
    logic [2:0] mx [3];
    logic [1:0] g;
    scd_gain_type eg;
    logic sup;
    mx = '{SCD_MUX_NORMAL, SCD_MUX_SHORT, SCD_MUX_SUPPLY};
    for (int m = 0; m < 3; m++) begin
      sup = (mx[m] == SCD_MUX_SUPPLY);
      for (int k = 0; k < 4; k++) begin
        // Supply monitoring is only legal at unity gain
        g = sup ? 2'h0 : 2'(k);
        eg = (g == 2'h2) ? SCD_GAIN_X8 : (g == 2'h1) ? SCD_GAIN_X2 : SCD_GAIN_X1;
        for (int ch = 0; ch < SCD_NUM_CH; ch++) begin
          cfg.chan[ch] = '{mux: mx[m], gain: g};
        end
        cfg.ref_high_level_select = k[0];
        cfg.ref_buffer_powerdown = k[1];
        wcfg();
        chk("ref level", k[0], ref_high);
        chk("refbuf", k[1], refbuf);
        for (int ch = 0; ch < SCD_NUM_CH; ch++) begin
          chk("mux", mx[m], ana[ch].mux);
          chk("supply pos", sup, ana[ch].supply_monitor_pos);
          chk("dvdd mon", sup && SCD_DVDD_MON_CHANS[ch], ana[ch].mon_dvdd);
          chk("short", mx[m] == SCD_MUX_SHORT, ana[ch].short_in);
          chk("gain", eg, ana[ch].gain);
        end
      end
    end
    cfg = SCD_CFG_RST;
    wcfg();
  endtask

  task automatic t_clock();
    int n;
    logic p;
    sel = 1'b1;
    cfg.clk_out_en = 1'b1;
    wcfg();
    chk("pin enable", 1, pin_oe);
    n = 0;
    p = pin;
    repeat (1000) begin
      tick(1);
      n += (pin && !p);
      p = pin;
    end
    chk("oscillator edges", 1, n >= 326 && n <= 329);
    cfg.clk_out_en = 1'b0;
    wcfg();
    chk("pin float", 0, pin_oe);
    chk("pin idle", 0, pin);
    cfg.clk_out_en = 1'b1;
    sel = 1'b0;
    wcfg();
    chk("pin as input", 0, pin_oe);
  endtask

  task automatic t_settle(input int per);
    int n;
    start = 1'b0;
    tick(3);
    start = 1'b1;
    wait_frame(4 * per, n);
    chk("first frame delay", 1, n >= 3 * per - 8 && n <= 3 * per + 12);
    chk("converting", 1, conv);
    chk_frame();
    wait_frame(2 * per, n);
    chk("frame interval", 1, n >= per - 1 && n <= per + 2);
  endtask

  task automatic t_step();
    int n;
    pat = 8'haa;
    // Step lands right after a frame, so the third frame must be settled
    repeat (3) wait_frame(2 * PER_INT, n);
    chk_frame();
  endtask

  task automatic t_overrun();
    logic [15:0] c0;
    stall = 1'b1;
    tick(20 * 782);
    chk("overrun", 1, overrun);
    start = 1'b0;
    tick(3);
    c0 = taken;
    stall = 1'b0;
    tick(60);
    chk("frames held", SCD_FIFO_DEPTH + 1, 32'(taken - c0));
    start = 1'b1;
    tick(3);
    chk("overrun after start", 0, overrun);
    start = 1'b0;
    tick(3);
  endtask

  initial begin
    {resetn, sel, start, cfg_we, stall} = '0;
    cfg = SCD_CFG_RST;
    pat = 8'h55;
    miscompares = 0;
    comparisons = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    tick(2);
    t_reset();
    t_chan_cfg();
    t_clock();
    t_settle(PER_EXT);
    sel = 1'b1;
    t_settle(PER_INT);
    t_step();
    t_overrun();
    give_verdict();
  end
endmodule
